// ### lmd_pkg.sv
// Purpose: shared constants and types for the lcd mux drive timing block
// Assumes: core clock of 25 MHz, one clock domain
// Notes: drive levels are coded 0 = ground .. 3 = panel_drive_rail
package lmd_pkg;
	typedef enum logic [1:0] {
		LMD_STATIC = 2'b00,
		LMD_MUX2 = 2'b01,
		LMD_MUX3 = 2'b10,
		LMD_MUX4 = 2'b11
	} lmd_mode_t;
	typedef enum logic {
		LMD_BIAS_THIRD = 1'b0,
		LMD_BIAS_HALF = 1'b1
	} lmd_bias_t;
	typedef enum logic [1:0] {
		LMD_SC_IDLE = 2'b00,
		LMD_SC_RUN = 2'b01,
		LMD_SC_COMMIT = 2'b10
	} lmd_scan_t;

	localparam int LMD_NUM_BP = 4;
	localparam int LMD_NUM_SEG = 32;
	localparam int LMD_ADDR_W = 5;
	localparam int LMD_ROW_W = 4;

	// drive level codes
	localparam logic [1:0] LMD_LVL_VSS = 2'h0;
	localparam logic [1:0] LMD_LVL_LO = 2'h1;
	localparam logic [1:0] LMD_LVL_HI = 2'h2;
	localparam logic [1:0] LMD_LVL_RAIL = 2'h3;

	// frame = selected clock / 24, split evenly among the phases
	localparam int LMD_FRAME_DIV = 24;
	localparam logic [4:0] LMD_FRAME_LAST = 5'(LMD_FRAME_DIV - 1);
	localparam logic [4:0] LMD_LEN_STATIC = 5'(LMD_FRAME_DIV / 1);
	localparam logic [4:0] LMD_LEN_MUX2 = 5'(LMD_FRAME_DIV / 2);
	localparam logic [4:0] LMD_LEN_MUX3 = 5'(LMD_FRAME_DIV / 3);
	localparam logic [4:0] LMD_LEN_MUX4 = 5'(LMD_FRAME_DIV / 4);

	// values after reset
	localparam lmd_mode_t LMD_RST_MODE = LMD_MUX4;
	localparam lmd_bias_t LMD_RST_BIAS = LMD_BIAS_THIRD;
	localparam logic [4:0] LMD_RST_PTR = 5'h00;
	localparam logic [2:0] LMD_RST_SUB = 3'h0;
	localparam logic [1:0] LMD_RST_BLINK = 2'h0;
	localparam logic LMD_RST_BANK = 1'b0;

	// host quiet time after power-on
	localparam int LMD_POR_TIME_US = 1000;
	localparam int LMD_CORE_CLK_KHZ = 25000;
	localparam int LMD_POR_CYCLES = LMD_POR_TIME_US * LMD_CORE_CLK_KHZ / 1000;

	// internal oscillator half period in core cycles
	localparam int LMD_OSC_HALF_DFLT = 4;
endpackage : lmd_pkg

// ### lmd_disp_ram.sv
// Purpose: display memory, one word per segment column, one bit per row
// Assumes: single clock, masked write, registered read
// Notes: read data appear one cycle after the address
`timescale 1ns/1ps
module lmd_disp_ram #(
	parameter int DEPTH = 32,
	parameter int AW = 5,
	parameter int WIDTH = 4
) (
	// clock
	input wire logic clk_i,
	// write port
	input wire logic wr_en_i,
	input wire logic [AW-1:0] wr_addr_i,
	input wire logic [WIDTH-1:0] wr_data_i,
	input wire logic [WIDTH-1:0] wr_mask_i,
	// read port
	input wire logic [AW-1:0] rd_addr_i,
	output logic [WIDTH-1:0] rd_data_o
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= (mem[wr_addr_i] & ~wr_mask_i) |
				(wr_data_i & wr_mask_i);
		end
		rd_data_o <= mem[rd_addr_i];
	end
endmodule : lmd_disp_ram

// ### lmd_timing.sv
// Purpose: clock source, frame timing, cascade sync and backplane/segment
//  drive sequencing of a multiplexed segment lcd driver
// Assumes: all inputs synchronous to core_clk_i; commands are 1-cycle strobes
// Notes: outputs are level codes, the analog selector turns them to voltages
`timescale 1ns/1ps
// Contract
// - reset drives all backplane and segment outputs to rail
// - reset selects 1:4 drive, third bias
// - reset clears pointer, subaddress, bus state
// - reset clears banks, blink, disables display
// - strap low: internal oscillator driven out
// - strap high: clock pin is input
// - frame is selected clock divided by 24
// - timing moves memory rows to segments
// - drive configuration set only by command
// - static drive: one backplane, two levels
// - 1:2 drive supports half and third bias
// - half bias closes divider bypass switch, except in static drive
// - 1:3 drive sequences three backplanes
// - 1:4 drive sequences four backplanes
// - half bias allowed in 1:3, 1:4
// - output rows start at row zero, or at row two with the out bank set in static and 1:2
module lmd_timing
	import lmd_pkg::*;
#(
	parameter int OSC_HALF = lmd_pkg::LMD_OSC_HALF_DFLT,
	parameter int POR_CYCLES = lmd_pkg::LMD_POR_CYCLES
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	// clock source strap and two-way clock pin
	input wire logic clock_source_select_i,
	input wire logic clk_pin_i,
	output logic clk_pin_o,
	output logic clk_pin_oe_o,
	// open-drain cascade sync pin
	input wire logic sync_pin_i,
	output logic sync_pin_o,
	output logic sync_pin_oe_o,
	// commands from the decoder
	input wire logic mode_set_i,
	input wire lmd_pkg::lmd_mode_t mode_cmd_i,
	input wire lmd_pkg::lmd_bias_t bias_cmd_i,
	input wire logic enable_cmd_i,
	input wire logic bank_set_i,
	input wire logic in_bank_cmd_i,
	input wire logic out_bank_cmd_i,
	input wire logic blink_set_i,
	input wire logic [1:0] blink_cmd_i,
	input wire logic load_ptr_i,
	input wire logic [4:0] ptr_cmd_i,
	input wire logic dev_sel_i,
	input wire logic [2:0] subaddr_cmd_i,
	// display memory write
	input wire logic ram_wr_i,
	input wire logic [lmd_pkg::LMD_ADDR_W-1:0] ram_addr_i,
	input wire logic [lmd_pkg::LMD_ROW_W-1:0] ram_data_i,
	input wire logic [lmd_pkg::LMD_ROW_W-1:0] ram_mask_i,
	// panel drive
	output logic [lmd_pkg::LMD_NUM_BP-1:0][1:0] backplane_output_o,
	output logic [lmd_pkg::LMD_NUM_SEG-1:0][1:0] segment_output_o,
	output logic bias_bypass_o,
	output logic frame_pulse_o,
	// state seen by the rest of the chip
	output logic host_ready_o,
	output logic bus_init_o,
	output lmd_pkg::lmd_mode_t drive_mode_o,
	output lmd_pkg::lmd_bias_t bias_mode_o,
	output logic display_on_o,
	output logic [1:0] blink_mode_o,
	output logic in_bank_o,
	output logic out_bank_o,
	output logic [4:0] data_pointer_o,
	output logic [2:0] subaddr_cnt_o
);
	import lmd_pkg::*;

	localparam logic [7:0] OSC_LAST = 8'(OSC_HALF - 1);
	localparam logic [15:0] POR_LAST = 16'(POR_CYCLES - 1);

	function automatic logic [4:0] phase_len(input lmd_mode_t m);
		unique case (m)
			LMD_STATIC: phase_len = LMD_LEN_STATIC;
			LMD_MUX2: phase_len = LMD_LEN_MUX2;
			LMD_MUX3: phase_len = LMD_LEN_MUX3;
			LMD_MUX4: phase_len = LMD_LEN_MUX4;
		endcase
	endfunction : phase_len

	// which backplane is selected in a phase; spare outputs copy a partner
	function automatic logic bp_active(input int g, input lmd_mode_t m,
		input logic [1:0] ph);
		unique case (m)
			LMD_STATIC: bp_active = 1'b1;
			LMD_MUX2: bp_active = (g[0] == ph[0]);
			LMD_MUX3: bp_active = (g == 3) ? (ph == 2'h1) : (2'(g) == ph);
			LMD_MUX4: bp_active = (2'(g) == ph);
		endcase
	endfunction : bp_active

	// configuration registers
	lmd_mode_t mode, next_mode;
	lmd_bias_t bias, next_bias;
	logic disp_on, next_disp_on;
	logic [1:0] blink, next_blink;
	logic in_bank, next_in_bank, out_bank, next_out_bank;
	logic [4:0] data_ptr, next_data_ptr;
	logic [2:0] sub_cnt, next_sub_cnt;

	always_comb begin
		next_mode = mode;
		next_bias = bias;
		next_disp_on = disp_on;
		next_blink = blink;
		next_in_bank = in_bank;
		next_out_bank = out_bank;
		next_data_ptr = data_ptr;
		next_sub_cnt = sub_cnt;
		if (mode_set_i) begin
			next_mode = mode_cmd_i;
			// any bias with any mux mode
			next_bias = bias_cmd_i;
			next_disp_on = enable_cmd_i;
		end
		if (bank_set_i) begin
			next_in_bank = in_bank_cmd_i;
			next_out_bank = out_bank_cmd_i;
		end
		if (blink_set_i) begin
			next_blink = blink_cmd_i;
		end
		if (load_ptr_i) begin
			next_data_ptr = ptr_cmd_i;
		end
		if (dev_sel_i) begin
			next_sub_cnt = subaddr_cmd_i;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			mode <= LMD_RST_MODE;
			bias <= LMD_RST_BIAS;
			disp_on <= 1'b0;
			blink <= LMD_RST_BLINK;
			in_bank <= LMD_RST_BANK;
			out_bank <= LMD_RST_BANK;
			data_ptr <= LMD_RST_PTR;
			sub_cnt <= LMD_RST_SUB;
		end else begin
			mode <= next_mode;
			bias <= next_bias;
			disp_on <= next_disp_on;
			blink <= next_blink;
			in_bank <= next_in_bank;
			out_bank <= next_out_bank;
			data_ptr <= next_data_ptr;
			sub_cnt <= next_sub_cnt;
		end
	end

	// power-on quiet time
	logic [15:0] por_cnt, next_por_cnt;
	logic por_done, next_por_done;

	always_comb begin
		next_por_cnt = por_cnt;
		next_por_done = por_done;
		if (!por_done) begin
			next_por_cnt = por_cnt + 16'h0001;
			next_por_done = (por_cnt == POR_LAST);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			por_cnt <= 16'h0000;
			por_done <= 1'b0;
		end else begin
			por_cnt <= next_por_cnt;
			por_done <= next_por_done;
		end
	end

	// clock source
	logic [7:0] osc_cnt, next_osc_cnt;
	logic osc_clk, next_osc_clk;
	logic ext_prev, next_ext_prev;
	logic tick;

	always_comb begin
		next_osc_cnt = osc_cnt + 8'h01;
		next_osc_clk = osc_clk;
		if (osc_cnt == OSC_LAST) begin
			next_osc_cnt = 8'h00;
			next_osc_clk = ~osc_clk;
		end
		next_ext_prev = clk_pin_i;
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			osc_cnt <= 8'h00;
			osc_clk <= 1'b0;
			// follow the pin so that release brings no false edge
			ext_prev <= clk_pin_i;
		end else begin
			osc_cnt <= next_osc_cnt;
			osc_clk <= next_osc_clk;
			ext_prev <= next_ext_prev;
		end
	end

	// rising edge of the selected clock
	assign tick = clock_source_select_i ? (clk_pin_i & ~ext_prev) :
		(~osc_clk & (osc_cnt == OSC_LAST));
	// drive internal clock out for cascade
	assign clk_pin_oe_o = ~clock_source_select_i;
	assign clk_pin_o = osc_clk;

	// frame and phase timing
	logic [4:0] frame_cnt, next_frame_cnt;
	logic [4:0] slot_cnt, next_slot_cnt;
	logic [1:0] phase, next_phase;
	logic pol, next_pol;
	logic sync_prev, next_sync_prev;
	logic sync_fall, frame_tick, phase_step;

	assign sync_pin_oe_o = (frame_cnt == 5'h00);
	assign sync_pin_o = 1'b0;
	assign sync_fall = sync_prev & ~sync_pin_i & ~sync_pin_oe_o;
	assign frame_tick = tick & (frame_cnt == LMD_FRAME_LAST);
	assign phase_step = tick & ~frame_tick &
		(slot_cnt >= phase_len(mode) - 5'h01);

	always_comb begin
		next_frame_cnt = frame_cnt;
		next_slot_cnt = slot_cnt;
		next_phase = phase;
		next_pol = pol;
		next_sync_prev = sync_pin_i;
		if (sync_fall) begin
			next_frame_cnt = 5'h00;
			next_slot_cnt = 5'h00;
			next_phase = 2'h0;
		end else if (frame_tick) begin
			next_frame_cnt = 5'h00;
			next_slot_cnt = 5'h00;
			next_phase = 2'h0;
			next_pol = ~pol;
		end else if (phase_step) begin
			next_frame_cnt = frame_cnt + 5'h01;
			next_slot_cnt = 5'h00;
			// wrap after the mode's last phase
			next_phase = (phase == 2'(mode)) ? 2'h0 : phase + 2'h1;
		end else if (tick) begin
			next_frame_cnt = frame_cnt + 5'h01;
			next_slot_cnt = slot_cnt + 5'h01;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			frame_cnt <= 5'h00;
			slot_cnt <= 5'h00;
			phase <= 2'h0;
			pol <= 1'b0;
			sync_prev <= 1'b1;
		end else begin
			frame_cnt <= next_frame_cnt;
			slot_cnt <= next_slot_cnt;
			phase <= next_phase;
			pol <= next_pol;
			sync_prev <= next_sync_prev;
		end
	end

	// row transfer from display memory into the display register
	lmd_scan_t scan_st, next_scan_st;
	logic [5:0] scan_cnt, next_scan_cnt;
	logic pend, next_pend;
	logic [1:0] tgt_phase, next_tgt_phase, shown_phase, next_shown_phase;
	logic [1:0] tgt_row, next_tgt_row;
	logic tgt_pol, next_tgt_pol, shown_pol, next_shown_pol;
	logic [LMD_NUM_SEG-1:0] stage, next_stage, disp_reg, next_disp_reg;
	logic [LMD_ROW_W-1:0] rd_data;

	lmd_disp_ram #(
		.DEPTH(LMD_NUM_SEG),
		.AW(LMD_ADDR_W),
		.WIDTH(LMD_ROW_W)
	) u_ram (
		.clk_i(core_clk_i),
		.wr_en_i(ram_wr_i),
		.wr_addr_i(ram_addr_i),
		.wr_data_i(ram_data_i),
		.wr_mask_i(ram_mask_i),
		.rd_addr_i(scan_cnt[LMD_ADDR_W-1:0]),
		.rd_data_o(rd_data)
	);

	always_comb begin
		next_scan_st = scan_st;
		next_scan_cnt = scan_cnt;
		next_pend = pend | phase_step | frame_tick | sync_fall;
		next_tgt_phase = tgt_phase;
		next_tgt_row = tgt_row;
		next_tgt_pol = tgt_pol;
		next_shown_phase = shown_phase;
		next_shown_pol = shown_pol;
		next_stage = stage;
		next_disp_reg = disp_reg;
		unique case (scan_st)
			LMD_SC_IDLE: begin
				if (pend) begin
					next_pend = phase_step | frame_tick | sync_fall;
					next_scan_st = LMD_SC_RUN;
					next_scan_cnt = 6'h00;
					next_tgt_phase = phase;
					next_tgt_pol = pol;
					// rows from zero, alternate bank in static and 1:2
					next_tgt_row = (out_bank && (mode == LMD_STATIC ||
						mode == LMD_MUX2)) ? phase + 2'h2 : phase;
				end
			end
			LMD_SC_RUN: begin
				next_scan_cnt = scan_cnt + 6'h01;
				// read data lag the address by one cycle
				if (scan_cnt != 6'h00) begin
					next_stage[5'(scan_cnt - 6'h01)] = rd_data[tgt_row];
				end
				if (scan_cnt == 6'(LMD_NUM_SEG)) begin
					next_scan_st = LMD_SC_COMMIT;
				end
			end
			LMD_SC_COMMIT: begin
				next_disp_reg = stage;
				next_shown_phase = tgt_phase;
				next_shown_pol = tgt_pol;
				next_scan_st = LMD_SC_IDLE;
			end
			default: next_scan_st = LMD_SC_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			scan_st <= LMD_SC_IDLE;
			scan_cnt <= 6'h00;
			pend <= 1'b1;
			tgt_phase <= 2'h0;
			tgt_row <= 2'h0;
			tgt_pol <= 1'b0;
			shown_phase <= 2'h0;
			shown_pol <= 1'b0;
			stage <= '0;
			disp_reg <= '0;
		end else begin
			scan_st <= next_scan_st;
			scan_cnt <= next_scan_cnt;
			pend <= next_pend;
			tgt_phase <= next_tgt_phase;
			tgt_row <= next_tgt_row;
			tgt_pol <= next_tgt_pol;
			shown_phase <= next_shown_phase;
			shown_pol <= next_shown_pol;
			stage <= next_stage;
			disp_reg <= next_disp_reg;
		end
	end

	// drive level selection, per backplane and per segment
	logic [LMD_NUM_BP-1:0][1:0] next_bp;
	logic [LMD_NUM_SEG-1:0][1:0] next_seg;
	logic [1:0] sel_lvl, on_lvl, bp_idle_lvl, seg_off_lvl;

	always_comb begin
		sel_lvl = shown_pol ? LMD_LVL_RAIL : LMD_LVL_VSS;
		on_lvl = shown_pol ? LMD_LVL_VSS : LMD_LVL_RAIL;
		if (bias == LMD_BIAS_HALF) begin
			bp_idle_lvl = LMD_LVL_LO;
			seg_off_lvl = sel_lvl;
		end else begin
			bp_idle_lvl = shown_pol ? LMD_LVL_LO : LMD_LVL_HI;
			seg_off_lvl = shown_pol ? LMD_LVL_HI : LMD_LVL_LO;
		end
		// static drive uses only two levels
		if (mode == LMD_STATIC) begin
			seg_off_lvl = sel_lvl;
		end
	end

	for (genvar g = 0; g < LMD_NUM_BP; g++) begin : g_bp
		assign next_bp[g] = !disp_on ? LMD_LVL_RAIL :
			bp_active(g, mode, shown_phase) ? sel_lvl : bp_idle_lvl;
	end
	for (genvar g = 0; g < LMD_NUM_SEG; g++) begin : g_seg
		assign next_seg[g] = !disp_on ? LMD_LVL_RAIL :
			disp_reg[g] ? on_lvl : seg_off_lvl;
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			backplane_output_o <= {LMD_NUM_BP{LMD_LVL_RAIL}};
			segment_output_o <= {LMD_NUM_SEG{LMD_LVL_RAIL}};
			bias_bypass_o <= 1'b0;
			frame_pulse_o <= 1'b0;
		end else begin
			backplane_output_o <= next_bp;
			segment_output_o <= next_seg;
			// bypass centre impedance for half bias, except in static drive
			bias_bypass_o <= (bias == LMD_BIAS_HALF) && (mode != LMD_STATIC);
			frame_pulse_o <= frame_tick;
		end
	end

	assign host_ready_o = por_done;
	// bus interface held in init during reset
	assign bus_init_o = reset_i;
	assign drive_mode_o = mode;
	assign bias_mode_o = bias;
	assign display_on_o = disp_on;
	assign blink_mode_o = blink;
	assign in_bank_o = in_bank;
	assign out_bank_o = out_bank;
	assign data_pointer_o = data_ptr;
	assign subaddr_cnt_o = sub_cnt;

	chk_reset_rail: assert property (@(posedge core_clk_i)
		reset_i |=> (backplane_output_o == {LMD_NUM_BP{LMD_LVL_RAIL}}) &&
		(segment_output_o == {LMD_NUM_SEG{LMD_LVL_RAIL}}))
		else $error("outputs not at rail after reset");
	chk_reset_mode: assert property (@(posedge core_clk_i)
		reset_i |=> drive_mode_o == LMD_MUX4 && bias_mode_o == LMD_BIAS_THIRD)
		else $error("reset drive mode wrong");
	chk_reset_ptr: assert property (@(posedge core_clk_i)
		$past(reset_i) |-> data_pointer_o == 5'h00 && subaddr_cnt_o == 3'h0)
		else $error("pointer or subaddress not cleared");
	chk_reset_state: assert property (@(posedge core_clk_i)
		reset_i |=> !display_on_o && blink_mode_o == 2'h0 && !in_bank_o &&
		!out_bank_o) else $error("display enabled after reset");
	chk_host_wait: assert property (@(posedge core_clk_i)
		disable iff (reset_i) $rose(host_ready_o) |->
		$past(por_cnt) == POR_LAST) else $error("ready raised early");
	chk_clk_drive: assert property (@(posedge core_clk_i)
		!clock_source_select_i |-> clk_pin_oe_o && clk_pin_o == osc_clk)
		else $error("clock pin not driven");
	chk_clk_follow: assert property (@(posedge core_clk_i)
		disable iff (reset_i) clock_source_select_i |-> !clk_pin_oe_o &&
		tick == $rose(clk_pin_i)) else $error("external clock ignored");
	chk_frame_len: assert property (@(posedge core_clk_i)
		disable iff (reset_i) frame_tick && !sync_fall |=>
		frame_cnt == 5'h00 && frame_pulse_o ##1 !frame_pulse_o)
		else $error("frame divider wrong");
	chk_sync_align: assert property (@(posedge core_clk_i)
		disable iff (reset_i) sync_fall |=> frame_cnt == 5'h00 && phase == 2'h0)
		else $error("sync did not realign");
	chk_mode_cmd: assert property (@(posedge core_clk_i)
		disable iff (reset_i) !mode_set_i |=> $stable(drive_mode_o))
		else $error("mode changed without command");
	chk_phase_wrap: assert property (@(posedge core_clk_i)
		disable iff (reset_i) (phase_step || frame_tick) && !sync_fall &&
		phase == 2'(mode) |=> phase == 2'h0) else $error("phase did not wrap");
endmodule : lmd_timing

// ### lmd_cascade_peer.sv
// Purpose: far-side partner: a cascade neighbour that supplies the
//  external clock and can pull the shared sync line low
// Assumes: sync line is open drain with a pull-up outside this model
// Notes: the clock runs free from time zero and never stops
`timescale 1ns/1ps
module lmd_cascade_peer #(
	parameter int HALF = 6
) (
	// core clock
	input wire logic core_clk_i,
	// request from the bench to pull sync low
	input wire logic pull_i,
	// cascade lines
	output logic ext_clk_o,
	output logic sync_low_o
);
	int cnt = 0;
	initial ext_clk_o = 1'b0;
	initial sync_low_o = 1'b0;
	always @(posedge core_clk_i) begin
		cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
		if (cnt == HALF - 1) begin
			ext_clk_o <= !ext_clk_o;
		end
	end
	always @(posedge core_clk_i) begin
		sync_low_o <= pull_i;
	end
endmodule : lmd_cascade_peer

// ### testbench.sv
// Purpose: self-checking bench for the lcd mux drive timing block
// Assumes: inputs change at the falling edge, reset held 10 cycles at start and 3 cycles when reapplied
// Notes: oscillator half period is doubled and host quiet time is shortened
`timescale 1ns/1ps
module testbench;
	import lmd_pkg::*;
	localparam int OH = 8;
	localparam int FR = 48 * OH;
	localparam int EH = 6;
	logic core_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic strap = 1'b0;
	logic pull = 1'b0;
	logic ext_clk, peer_low, clk_o, clk_oe, sync_o, sync_oe;
	logic mode_set = 0, bank_set = 0, blink_set = 0, load_ptr = 0;
	logic dev_sel = 0, ram_wr = 0, en_cmd = 0, inb = 0, outb = 0;
	lmd_mode_t mode_cmd = LMD_STATIC;
	lmd_bias_t bias_cmd = LMD_BIAS_THIRD;
	logic [1:0] blink_cmd = 2'h0;
	logic [4:0] ptr_cmd = 5'h00, addr = 5'h00;
	logic [2:0] sub_cmd = 3'h0;
	logic [3:0] wdata = 4'h0, wmask = 4'hF;
	logic [3:0][1:0] bp;
	logic [31:0][1:0] seg;
	logic bypass, fpulse, hrdy, binit, dsp_on, in_bank, out_bank;
	lmd_mode_t dmode;
	lmd_bias_t dbias;
	logic [1:0] blink;
	logic [4:0] ptr;
	logic [2:0] sub;
	logic ph;
	int mismatches = 0, checks = 0, cycles = 0, n;
	wire clk_wire = clk_oe ? clk_o : ext_clk;
	wire sync_wire = !((sync_oe && !sync_o) || peer_low);
	always #20 core_clk_i = !core_clk_i;
	lmd_cascade_peer #(.HALF(EH)) peer (.core_clk_i(core_clk_i),
		.pull_i(pull), .ext_clk_o(ext_clk), .sync_low_o(peer_low));
	lmd_timing #(.OSC_HALF(OH), .POR_CYCLES(20)) dut (
		.core_clk_i(core_clk_i), .reset_i(reset_i),
		.clock_source_select_i(strap), .clk_pin_i(clk_wire),
		.clk_pin_o(clk_o), .clk_pin_oe_o(clk_oe), .sync_pin_i(sync_wire),
		.sync_pin_o(sync_o), .sync_pin_oe_o(sync_oe),
		.mode_set_i(mode_set), .mode_cmd_i(mode_cmd), .bias_cmd_i(bias_cmd),
		.enable_cmd_i(en_cmd), .bank_set_i(bank_set), .in_bank_cmd_i(inb),
		.out_bank_cmd_i(outb), .blink_set_i(blink_set),
		.blink_cmd_i(blink_cmd), .load_ptr_i(load_ptr), .ptr_cmd_i(ptr_cmd),
		.dev_sel_i(dev_sel), .subaddr_cmd_i(sub_cmd), .ram_wr_i(ram_wr),
		.ram_addr_i(addr), .ram_data_i(wdata), .ram_mask_i(wmask),
		.backplane_output_o(bp), .segment_output_o(seg),
		.bias_bypass_o(bypass), .frame_pulse_o(fpulse),
		.host_ready_o(hrdy), .bus_init_o(binit), .drive_mode_o(dmode),
		.bias_mode_o(dbias), .display_on_o(dsp_on), .blink_mode_o(blink),
		.in_bank_o(in_bank), .out_bank_o(out_bank),
		.data_pointer_o(ptr), .subaddr_cnt_o(sub));
	task automatic report_and_stop();
		if (mismatches == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : report_and_stop
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			report_and_stop();
		end
	end
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what,
				got, exp);
		end
	endtask : cmp
	task automatic nclk(input int k);
		repeat (k) @(negedge core_clk_i);
	endtask : nclk
	task automatic check_reset();
		for (int i = 0; i < 4; i++) cmp(16'(bp[i]), 16'h3, "backplane");
		for (int i = 0; i < 32; i++) cmp(16'(seg[i]), 16'h3, "segment");
		cmp(16'(dmode), 16'(LMD_MUX4), "reset mode");
		cmp(16'(dbias), 16'(LMD_BIAS_THIRD), "reset bias");
		cmp(16'({ptr, sub}), 16'h0, "pointer and subaddress");
		cmp(16'(binit), 16'h1, "bus init");
		cmp(16'({blink, in_bank, out_bank}), 16'h0, "blink and banks");
		cmp(16'(dsp_on), 16'h0, "display enable");
	endtask : check_reset
	task automatic set_mode(input lmd_mode_t m, input lmd_bias_t b);
		nclk(1);
		mode_cmd = m;
		bias_cmd = b;
		en_cmd = 1'b1;
		mode_set = 1'b1;
		nclk(1);
		mode_set = 1'b0;
		cmp(16'(dmode), 16'(m), "drive mode");
		cmp(16'(dbias), 16'(b), "bias mode");
	endtask : set_mode
	task automatic set_bank(input logic i, input logic o);
		nclk(1);
		{inb, outb, bank_set} = {i, o, 1'b1};
		nclk(1);
		bank_set = 1'b0;
		cmp(16'({in_bank, out_bank}), 16'({i, o}), "bank selectors");
	endtask : set_bank
	task automatic write_ram(input logic [4:0] a, input logic [3:0] d,
		input logic [3:0] m);
		nclk(1);
		{addr, wdata, wmask, ram_wr} = {a, d, m, 1'b1};
		nclk(1);
		ram_wr = 1'b0;
	endtask : write_ram
	task automatic to_pulse(output int k);
		k = 0;
		do begin
			nclk(1);
			k++;
		end while (fpulse !== 1'b1 && k < 4000);
	endtask : to_pulse
	// watch two frames, rebuilding each backplane level and segments 0 and 1 from the phase seen
	task automatic check_panel(input int nb, input logic half,
		input int r0, input logic [3:0] d0, input logic [3:0] d1);
		int k, prev, steps, j;
		logic p;
		logic [1:0] sel, uns, on_l, off_l;
		prev = -1;
		steps = 0;
		repeat (2 * FR) begin
			nclk(1);
			k = -1;
			for (int i = nb - 1; i >= 0; i--)
				if (bp[i] === 2'h0 || bp[i] === 2'h3) k = i;
			if (k < 0) begin
				cmp(16'h0, 16'h1, "no selected backplane");
			end else begin
				if (prev >= 0 && k != prev) begin
					cmp(16'(k), 16'((prev + 1) % nb), "phase order");
					steps++;
				end
				prev = k;
				p = (bp[k] === 2'h3);
				sel = p ? 2'h3 : 2'h0;
				uns = half ? 2'h1 : (p ? 2'h1 : 2'h2);
				on_l = p ? 2'h0 : 2'h3;
				off_l = (half || nb == 1) ? sel : (p ? 2'h2 : 2'h1);
				for (int i = 0; i < 4; i++) begin
					j = nb == 1 ? 0 : nb == 2 ? i % 2 : (nb == 3 && i == 3) ? 1 : i;
					cmp(16'(bp[i]), 16'(j == k ? sel : uns), "backplane");
				end
				cmp(16'(seg[0]), 16'(d0[k + r0] ? on_l : off_l), "seg 0");
				cmp(16'(seg[1]), 16'(d1[k + r0] ? on_l : off_l), "seg 1");
			end
		end
		cmp(16'(nb > 1 ? steps >= nb : steps == 0), 16'h1, "steps");
	endtask : check_panel
	initial begin
		nclk(10);
		check_reset();
		reset_i = 1'b0;
		nclk(19);
		cmp(16'(hrdy), 16'h0, "host ready early");
		nclk(1);
		cmp(16'(hrdy), 16'h1, "host ready");
		set_mode(LMD_MUX2, LMD_BIAS_HALF);
		set_bank(1'b1, 1'b1);
		nclk(1);
		{blink_cmd, ptr_cmd, sub_cmd} = {2'h3, 5'h1F, 3'h7};
		{blink_set, load_ptr, dev_sel} = 3'h7;
		nclk(1);
		{blink_set, load_ptr, dev_sel} = 3'h0;
		cmp(16'({blink, ptr, sub}), 16'({2'h3, 5'h1F, 3'h7}), "held");
		reset_i = 1'b1;
		nclk(3);
		check_reset();
		reset_i = 1'b0;
		nclk(20);
		cmp(16'(binit), 16'h0, "bus init released");
		cmp(16'(clk_oe), 16'h1, "clock pin driven");
		for (int i = 0; i < 2; i++) begin
			ph = clk_o;
			n = 0;
			do begin
				nclk(1);
				n++;
			end while (clk_o === ph && n < 100);
		end
		cmp(16'(n), 16'(OH), "oscillator half period");
		write_ram(5'h00, 4'h5, 4'hF);
		write_ram(5'h01, 4'hA, 4'hF);
		write_ram(5'h00, 4'hA, 4'h0);
		to_pulse(n);
		to_pulse(n);
		cmp(16'(n), 16'(FR), "internal frame length");
		cmp(16'(sync_oe && !sync_o), 16'h1, "sync low at frame start");
		for (int i = 0; i < 8; i++) begin
			set_mode(lmd_mode_t'(i % 4), lmd_bias_t'(i / 4));
			nclk(2);
			cmp(16'(bypass), 16'(i / 4 == 1 && i % 4 != 0), "bypass");
			nclk(2 * FR);
			check_panel(i % 4 + 1, 1'(i / 4), 0, 4'h5, 4'hA);
		end
		set_mode(LMD_MUX2, LMD_BIAS_THIRD);
		set_bank(1'b0, 1'b1);
		nclk(2 * FR);
		check_panel(2, 1'b0, 2, 4'h5, 4'hA);
		nclk(1);
		strap = 1'b1;
		nclk(2);
		cmp(16'(clk_oe), 16'h0, "clock pin released");
		to_pulse(n);
		to_pulse(n);
		to_pulse(n);
		cmp(16'(n), 16'(48 * EH), "external frame length");
		nclk(10 * EH);
		pull = 1'b1;
		nclk(3);
		pull = 1'b0;
		to_pulse(n);
		cmp(16'(n >= 46 * EH && n <= 48 * EH - 1), 16'h1, "realign");
		report_and_stop();
	end
endmodule : testbench
